// file: core/ldpf_cfg.svh
// Constants for the host-side data packet receiver of a point-to-point link.
// Assumes one byte per bit-time arrives from the link logic on its own clock.
// How it works
// - Payload is 4 to 64 bytes, whole doublewords
// - Only writes and read replies carry data
// - Each byte sits in its natural lane
// - One byte per bit-time, low byte first
// - Byte read reply bytes may be invalid
// - Doubleword write carries one to sixteen doublewords
// - Byte write: mask doubleword, then 1-8 data
// - Mask bit n enables data byte n
// - All thirty-two mask bits always sent
// - All-zero masks are legal
// - Byte write needs data except messages
// - Mask in bit-times 0-3, data from 4
// - Data after a command belongs to it
// - Write code bit two picks byte or doubleword
`ifndef LDPF_CFG_SVH
`define LDPF_CFG_SVH
`define LDPF_CODE_RD_REPLY 6'h30
`define LDPF_WR_SEL_HI 4
`define LDPF_WR_SEL_LO 3
`define LDPF_WR_SEL_VAL 2'h1
`define LDPF_WR_DWORD_BIT 2
`define LDPF_LAST_LANE 2'h3
`define LDPF_MAX_BW_DW 4'h8
`define LDPF_BLOCK_DW 5'h10
`define LDPF_ONE_DW 5'h01
`define LDPF_FULL_BE 4'hF
`endif

// file: core/ldpf_pkg.sv
// Types shared by the packet receiver, the link device model and the bench.
// Assumes the constants header is included by the files that need it.
package ldpf_pkg;
  // Parser states, Gray along idle, mask, data
  typedef enum logic [1:0] {
    LDPF_IDLE = 2'b00,
    LDPF_MASK = 2'b01,
    LDPF_DATA = 2'b11
  } ldpf_state_t;

  // Command header fields that announce a payload
  typedef struct packed {
    logic [5:0] code;
    logic [3:0] count;
    logic [3:0] addr_dw;
    logic byte_rd;
  } ldpf_cmd_t;

  // One received doubleword handed to the host
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] be;
    logic [3:0] idx;
    logic last;
    logic sure;
  } ldpf_word_t;
endpackage

// file: core/ldpf_sync2.sv
// Two-flop level synchroniser.
// Assumes an asynchronous active-high reset of the destination domain.
`timescale 1ns/100ps
module ldpf_sync2 (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_level,
  output logic o_level
);
  logic meta_q;
  logic sync_q;

  // First stage feeds only the second
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= i_level;
      sync_q <= meta_q;
    end
  end

  assign o_level = sync_q;
endmodule

// file: core/ldpf_host_rx.sv
// Host end of the data packet link: parses payloads from the link clock
// domain and hands doublewords, with lane enables, to the system clock.
// Assumes commands and bytes come from link logic on I_LINK_CLK.
`timescale 1ns/100ps
`include "ldpf_cfg.svh"
module ldpf_host_rx (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire logic I_LINK_CLK,
  input wire logic I_LINK_CMD_VALID,
  input wire ldpf_pkg::ldpf_cmd_t I_LINK_CMD,
  input wire logic I_LINK_DATA_VALID,
  input wire logic [7:0] I_LINK_DATA,
  output logic O_WORD_VALID,
  output ldpf_pkg::ldpf_word_t O_WORD,
  output logic O_PKT_ERR
);
  // -------------------------------------------------------------------
  // Decode helpers
  // -------------------------------------------------------------------
  // Sized write codes 001xxx and 101xxx
  function automatic logic is_write(input logic [5:0] code);
    is_write = (code[`LDPF_WR_SEL_HI:`LDPF_WR_SEL_LO] == `LDPF_WR_SEL_VAL);
  endfunction

  // Lane enables of data doubleword k from the mask doubleword
  function automatic logic [3:0] mask_be(input logic [31:0] mask,
                                          input logic [3:0] k);
    mask_be = mask[{k[2:0], 2'b00} +: 4]; // Legal byte writes stop at 8
  endfunction

  // -------------------------------------------------------------------
  // Link-domain reset
  // -------------------------------------------------------------------
  logic lrst_meta_q;
  logic lrst_q;

  // Asserts at once, releases on the link clock
  always_ff @(posedge I_LINK_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      lrst_meta_q <= 1'b1;
      lrst_q <= 1'b1;
    end else begin
      lrst_meta_q <= 1'b0;
      lrst_q <= lrst_meta_q;
    end
  end

  // -------------------------------------------------------------------
  // Link-domain parser
  // -------------------------------------------------------------------
  ldpf_pkg::ldpf_state_t state_q, state_d;
  logic [31:0] mask_q, mask_d;
  logic [23:0] asm_q, asm_d;
  logic [1:0] lane_q, lane_d;
  logic [4:0] left_q, left_d;
  logic [3:0] base_q, base_d;
  logic [3:0] ord_q, ord_d;
  logic bw_q, bw_d;
  logic sure_q, sure_d;
  ldpf_pkg::ldpf_word_t hold_q, hold_d;
  logic wtog_q, wtog_d;
  logic etog_q, etog_d;
  logic cmd_wr;
  logic cmd_rd;
  logic cmd_bw;
  logic [4:0] cmd_ndw;
  logic cmd_bad;

  // Command decode; replies and writes are the only payload carriers
  always_comb begin
    cmd_wr = is_write(I_LINK_CMD.code);
    cmd_rd = (I_LINK_CMD.code == `LDPF_CODE_RD_REPLY);
    cmd_bw = cmd_wr && !I_LINK_CMD.code[`LDPF_WR_DWORD_BIT];
    // Byte write count covers the mask doubleword too
    cmd_ndw = cmd_bw ? {1'b0, I_LINK_CMD.count} :
              ({1'b0, I_LINK_CMD.count} + `LDPF_ONE_DW);
    // Wrap past the aligned block, or too much byte-write data
    cmd_bad = (({1'b0, I_LINK_CMD.addr_dw} + cmd_ndw) > `LDPF_BLOCK_DW)
              || (cmd_bw && (I_LINK_CMD.count > `LDPF_MAX_BW_DW));
  end

  // Next values of the parser; errors still parse to stay in step
  always_comb begin
    state_d = state_q;
    mask_d = mask_q;
    asm_d = asm_q;
    lane_d = lane_q;
    left_d = left_q;
    base_d = base_q;
    ord_d = ord_q;
    bw_d = bw_q;
    sure_d = sure_q;
    hold_d = hold_q;
    wtog_d = wtog_q;
    etog_d = etog_q;
    if (I_LINK_CMD_VALID && (cmd_wr || cmd_rd)) begin
      // A new command cuts off any unfinished payload
      if (state_q != ldpf_pkg::LDPF_IDLE || cmd_bad) begin
        etog_d = !etog_q;
      end
      lane_d = 2'b00;
      ord_d = 4'h0;
      left_d = cmd_ndw;
      base_d = I_LINK_CMD.addr_dw;
      bw_d = cmd_bw;
      sure_d = !(cmd_rd && I_LINK_CMD.byte_rd);
      mask_d = 32'h0000_0000;
      state_d = cmd_bw ? ldpf_pkg::LDPF_MASK : ldpf_pkg::LDPF_DATA;
    end else if (I_LINK_DATA_VALID) begin
      unique case (state_q)
        ldpf_pkg::LDPF_IDLE: begin
          etog_d = !etog_q;
        end
        ldpf_pkg::LDPF_MASK: begin
          mask_d[{lane_q, 3'b000} +: 8] = I_LINK_DATA;
          lane_d = lane_q + 2'b01;
          if (lane_q == `LDPF_LAST_LANE) begin
            // Zero data doublewords only for message writes
            state_d = (left_q == 5'h00) ? ldpf_pkg::LDPF_IDLE :
                      ldpf_pkg::LDPF_DATA;
          end
        end
        ldpf_pkg::LDPF_DATA: begin
          lane_d = lane_q + 2'b01;
          if (lane_q != `LDPF_LAST_LANE) begin
            asm_d[{lane_q, 3'b000} +: 8] = I_LINK_DATA;
          end else begin
            hold_d.data = {I_LINK_DATA, asm_q};
            hold_d.be = bw_q ? mask_be(mask_q, ord_q) : `LDPF_FULL_BE;
            hold_d.idx = base_q + ord_q;
            hold_d.last = (left_q == `LDPF_ONE_DW);
            hold_d.sure = sure_q;
            wtog_d = !wtog_q;
            ord_d = ord_q + 4'h1;
            left_d = left_q - `LDPF_ONE_DW;
            if (left_q == `LDPF_ONE_DW) begin
              state_d = ldpf_pkg::LDPF_IDLE;
            end
          end
        end
        default: begin
          state_d = ldpf_pkg::LDPF_IDLE;
        end
      endcase
    end
  end

  // Parser registers on the link clock
  always_ff @(posedge I_LINK_CLK or posedge lrst_q) begin
    if (lrst_q) begin
      state_q <= ldpf_pkg::LDPF_IDLE;
      mask_q <= 32'h0000_0000;
      asm_q <= 24'h00_0000;
      lane_q <= 2'b00;
      left_q <= 5'h00;
      base_q <= 4'h0;
      ord_q <= 4'h0;
      bw_q <= 1'b0;
      sure_q <= 1'b1;
      hold_q <= '0;
      wtog_q <= 1'b0;
      etog_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mask_q <= mask_d;
      asm_q <= asm_d;
      lane_q <= lane_d;
      left_q <= left_d;
      base_q <= base_d;
      ord_q <= ord_d;
      bw_q <= bw_d;
      sure_q <= sure_d;
      hold_q <= hold_d;
      wtog_q <= wtog_d;
      etog_q <= etog_d;
    end
  end

  // -------------------------------------------------------------------
  // Crossing into the system clock
  // -------------------------------------------------------------------
  // Toggles carry events; the held word stays put for four bit-times,
  // far longer than the synchroniser needs, so it is read directly.
  logic wtog_s;
  logic etog_s;
  logic wseen_q, wseen_d;
  logic eseen_q, eseen_d;
  logic valid_q, valid_d;
  logic err_q, err_d;
  ldpf_pkg::ldpf_word_t word_q, word_d;

  ldpf_sync2 u_word_sync (
    .i_clk(I_SYS_CLK),
    .i_reset(I_RESET),
    .i_level(wtog_q),
    .o_level(wtog_s)
  );

  ldpf_sync2 u_err_sync (
    .i_clk(I_SYS_CLK),
    .i_reset(I_RESET),
    .i_level(etog_q),
    .o_level(etog_s)
  );

  // Edge of each toggle becomes a one-cycle pulse
  always_comb begin
    wseen_d = wtog_s;
    eseen_d = etog_s;
    valid_d = (wtog_s != wseen_q);
    err_d = (etog_s != eseen_q);
    word_d = (wtog_s != wseen_q) ? hold_q : word_q;
  end

  // System-side output registers
  always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      wseen_q <= 1'b0;
      eseen_q <= 1'b0;
      valid_q <= 1'b0;
      err_q <= 1'b0;
      word_q <= '0;
    end else begin
      wseen_q <= wseen_d;
      eseen_q <= eseen_d;
      valid_q <= valid_d;
      err_q <= err_d;
      word_q <= word_d;
    end
  end

  assign O_WORD_VALID = valid_q;
  assign O_WORD = word_q;
  assign O_PKT_ERR = err_q;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  logic emit;
  logic [3:0] prev_idx_q;

  assign emit = (wtog_d != wtog_q);

  // Index of the previous doubleword, for the ascending check
  always_ff @(posedge I_LINK_CLK or posedge lrst_q) begin
    if (lrst_q) begin
      prev_idx_q <= 4'h0;
    end else if (emit) begin
      prev_idx_q <= hold_d.idx;
    end
  end

  sequence s_mask_last;
    state_q == ldpf_pkg::LDPF_MASK && lane_q == `LDPF_LAST_LANE
      && I_LINK_DATA_VALID && !I_LINK_CMD_VALID;
  endsequence

  property p_mask_four;
    @(posedge I_LINK_CLK) disable iff (lrst_q)
      s_mask_last |=> state_q != ldpf_pkg::LDPF_MASK && lane_q == 2'b00;
  endproperty
  a_mask_four: assert property (p_mask_four)
    else $error("mask phase not four bytes");

  property p_msg_only;
    @(posedge I_LINK_CLK) disable iff (lrst_q)
      s_mask_last ##0 (left_q == 5'h00) |=> state_q == ldpf_pkg::LDPF_IDLE
        && $stable(wtog_q);
  endproperty
  a_msg_only: assert property (p_msg_only)
    else $error("mask-only write emitted data");

  property p_bw_mask_first;
    @(posedge I_LINK_CLK) disable iff (lrst_q)
      I_LINK_CMD_VALID && is_write(I_LINK_CMD.code)
        && !I_LINK_CMD.code[`LDPF_WR_DWORD_BIT]
        |=> state_q == ldpf_pkg::LDPF_MASK && mask_q == 32'h0000_0000;
  endproperty
  a_bw_mask_first: assert property (p_bw_mask_first)
    else $error("byte write did not start with mask");

  property p_low_byte_first;
    @(posedge I_LINK_CLK) disable iff (lrst_q)
      state_q == ldpf_pkg::LDPF_DATA && lane_q == 2'b00
        && I_LINK_DATA_VALID && !I_LINK_CMD_VALID
        |=> asm_q[7:0] == $past(I_LINK_DATA);
  endproperty
  a_low_byte_first: assert property (p_low_byte_first)
    else $error("first data byte not in low lane");

  property p_top_lane;
    @(posedge I_LINK_CLK) disable iff (lrst_q)
      emit |=> hold_q.data[31:24] == $past(I_LINK_DATA)
        && hold_q.data[23:0] == $past(asm_q);
  endproperty
  a_top_lane: assert property (p_top_lane)
    else $error("doubleword lanes misplaced");

  property p_ascending;
    @(posedge I_LINK_CLK) disable iff (lrst_q)
      emit && ord_q != 4'h0 |-> hold_d.idx == prev_idx_q + 4'h1;
  endproperty
  a_ascending: assert property (p_ascending)
    else $error("doublewords not ascending");

  property p_mask_enables;
    @(posedge I_LINK_CLK) disable iff (lrst_q)
      emit && bw_q |=> hold_q.be == 4'($past(mask_q) >> {$past(ord_q), 2'b00});
  endproperty
  a_mask_enables: assert property (p_mask_enables)
    else $error("byte enables not from mask");

  property p_stray_data;
    @(posedge I_LINK_CLK) disable iff (lrst_q)
      state_q == ldpf_pkg::LDPF_IDLE && I_LINK_DATA_VALID && !I_LINK_CMD_VALID
        |=> etog_q != $past(etog_q);
  endproperty
  a_stray_data: assert property (p_stray_data)
    else $error("data without command not flagged");

  property p_no_wrap;
    @(posedge I_LINK_CLK) disable iff (lrst_q)
      I_LINK_CMD_VALID && (is_write(I_LINK_CMD.code) || cmd_rd)
        && ({1'b0, I_LINK_CMD.addr_dw} + cmd_ndw) > `LDPF_BLOCK_DW
        |=> etog_q != $past(etog_q);
  endproperty
  a_no_wrap: assert property (p_no_wrap)
    else $error("wrapping payload not flagged");

  property p_handoff;
    @(posedge I_SYS_CLK) disable iff (I_RESET)
      wtog_s != wseen_q |=> O_WORD_VALID ##1 !O_WORD_VALID[*2];
  endproperty
  a_handoff: assert property (p_handoff)
    else $error("word pulse malformed");
endmodule

// file: verif/ldpf_link_dev.sv
// Link-side device model: sends command headers and payload bytes.
// Assumes the bench fills pay[] and calls send, then idle.
`timescale 1ns/100ps
module ldpf_link_dev (
  input wire logic i_link_clk,
  output logic o_cmd_valid,
  output ldpf_pkg::ldpf_cmd_t o_cmd,
  output logic o_data_valid,
  output logic [7:0] o_data
);
  // ----------------------------------------
  // Payload store
  // ----------------------------------------
  // Bytes in bit-time order, mask bytes first on byte writes
  logic [7:0] pay [0:127];

  // Quiet lines toggle, so a stale byte is never mistaken for data
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = '0;
    o_data_valid = 1'b0;
    o_data = 8'h00;
  end

  // Command, then its bytes one per bit-time; gap stalls before byte 2
  task automatic send(input ldpf_pkg::ldpf_cmd_t c, input int n,
                      input int base, input int gap);
    @(posedge i_link_clk);
    #1;
    o_data_valid = 1'b0;
    o_data = ~o_data;
    o_cmd_valid = 1'b1;
    o_cmd = c;
    for (int i = 0; i < n; i++) begin
      @(posedge i_link_clk);
      #1;
      o_cmd_valid = 1'b0;
      o_cmd = ~o_cmd;
      if (i == 2) begin
        repeat (gap) begin
          o_data_valid = 1'b0;
          o_data = ~o_data;
          @(posedge i_link_clk);
          #1;
        end
      end
      o_data_valid = 1'b1;
      o_data = pay[base + i];
    end
  endtask

  // Idle link cycles after a packet
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge i_link_clk);
      #1;
      o_cmd_valid = 1'b0;
      o_cmd = ~o_cmd;
      o_data_valid = 1'b0;
      o_data = ~o_data;
    end
  endtask
endmodule

// file: verif/link_data_packet_framer_test.sv
// Self-checking bench for the host packet receiver.
// Assumes the link device model drives all link inputs except I_LINK_CLK, which the bench makes.
`timescale 1ns/100ps
module link_data_packet_framer_test;
  logic sys_clk;
  logic link_clk;
  logic reset;
  logic cmd_valid;
  ldpf_pkg::ldpf_cmd_t cmd;
  logic data_valid;
  logic [7:0] data;
  logic word_valid;
  ldpf_pkg::ldpf_word_t word;
  logic pkt_err;
  ldpf_pkg::ldpf_word_t got_q [$];
  ldpf_pkg::ldpf_word_t exp_q [$];
  int errs_seen;
  int err_base;
  int num_errors;
  int checks_done;

  // ----------------------------------------
  // Clocks, design and device
  // ----------------------------------------
  always #4 sys_clk = ~sys_clk;
  // Offset start keeps link edges off the system edges
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  ldpf_host_rx u_dut (
    .I_SYS_CLK(sys_clk),
    .I_RESET(reset),
    .I_LINK_CLK(link_clk),
    .I_LINK_CMD_VALID(cmd_valid),
    .I_LINK_CMD(cmd),
    .I_LINK_DATA_VALID(data_valid),
    .I_LINK_DATA(data),
    .O_WORD_VALID(word_valid),
    .O_WORD(word),
    .O_PKT_ERR(pkt_err)
  );

  ldpf_link_dev u_dev (
    .i_link_clk(link_clk),
    .o_cmd_valid(cmd_valid),
    .o_cmd(cmd),
    .o_data_valid(data_valid),
    .o_data(data)
  );

  // Pulses last one cycle, so sample every system edge
  always @(posedge sys_clk) begin
    if (word_valid === 1'b1)
      got_q.push_back(word);
    if (pkt_err === 1'b1)
      errs_seen++;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [47:0] exp,
                       input logic [47:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic ldpf_pkg::ldpf_cmd_t mk(input logic [5:0] code,
      input logic [3:0] cnt, input logic [3:0] adr, input logic br);
    ldpf_pkg::ldpf_cmd_t c;
    c.code = code;
    c.count = cnt;
    c.addr_dw = adr;
    c.byte_rd = br;
    return c;
  endfunction

  // Expected words of one packet; a short send yields whole dwords only
  task automatic plan(input ldpf_pkg::ldpf_cmd_t c, input int n,
                      input int b);
    ldpf_pkg::ldpf_word_t w;
    logic [31:0] m;
    logic bw;
    int s;
    int nd;
    bw = (c.code[4:3] == 2'b01) && !c.code[2];
    s = bw ? 4 : 0;
    m = {u_dev.pay[b+3], u_dev.pay[b+2], u_dev.pay[b+1], u_dev.pay[b]};
    nd = 0;
    if (c.code[4:3] == 2'b01 || c.code == 6'h30)
      nd = int'(c.count) + (bw ? 0 : 1);
    for (int k = 0; k < nd && s + 4 * k + 4 <= n; k++) begin
      w.data = {u_dev.pay[b+s+4*k+3], u_dev.pay[b+s+4*k+2],
                u_dev.pay[b+s+4*k+1], u_dev.pay[b+s+4*k]};
      w.be = bw ? m[4*k +: 4] : 4'hF;
      w.idx = c.addr_dw + k[3:0];
      w.last = (k == nd - 1);
      w.sure = !(c.code == 6'h30 && c.byte_rd);
      exp_q.push_back(w);
    end
  endtask

  task automatic pkt(input ldpf_pkg::ldpf_cmd_t c, input int n,
                     input int b, input int gap);
    plan(c, n, b);
    u_dev.send(c, n, b, gap);
  endtask

  // Bounded wait for the words, then compare words and fault pulses
  task automatic judge(input int err_exp);
    int t;
    u_dev.idle(2);
    t = 0;
    while (got_q.size() < exp_q.size() && t < 80) begin
      @(posedge sys_clk);
      t++;
    end
    repeat (8) @(posedge sys_clk);
    check("word count", exp_q.size(), got_q.size());
    for (int i = 0; i < exp_q.size() && i < got_q.size(); i++)
      check("word", exp_q[i], got_q[i]);
    check("fault pulses", err_exp, errs_seen - err_base);
    exp_q.delete();
    got_q.delete();
    err_base = errs_seen;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Single dword for both doubleword write codes and the read reply
  task automatic t_single();
    logic [5:0] codes [3] = '{6'h0C, 6'h2C, 6'h30};
    for (int i = 0; i < 3; i++) begin
      pkt(mk(codes[i], 4'h0, 4'h3, 1'b0), 4, 4 * i, 0);
      judge(0);
    end
  endtask

  // Full 64-byte write, back to back with a byte-read reply
  task automatic t_long();
    pkt(mk(6'h2C, 4'hF, 4'h0, 1'b0), 64, 0, 0);
    pkt(mk(6'h30, 4'h3, 4'hC, 1'b1), 16, 64, 0);
    judge(0);
  endtask

  // Byte writes: masks first, widest, all-zero, and mask-only
  task automatic t_bytes();
    pkt(mk(6'h28, 4'h2, 4'h5, 1'b0), 12, 0, 3);
    judge(0);
    pkt(mk(6'h08, 4'h8, 4'h0, 1'b0), 36, 20, 0);
    judge(0);
    pkt(mk(6'h28, 4'h1, 4'h2, 1'b0), 8, 100, 0);
    judge(0);
    pkt(mk(6'h08, 4'h0, 4'h0, 1'b0), 4, 60, 0);
    judge(0);
  endtask

  // Wrap past the block, stray byte, cut payload, oversize byte write
  task automatic t_faults();
    pkt(mk(6'h30, 4'h3, 4'hD, 1'b0), 16, 0, 0);
    judge(1);
    pkt(mk(6'h02, 4'h0, 4'h0, 1'b0), 1, 0, 0);
    judge(1);
    pkt(mk(6'h2C, 4'h1, 4'h4, 1'b0), 4, 8, 0);
    pkt(mk(6'h0C, 4'h0, 4'h9, 1'b0), 4, 40, 0);
    judge(1);
    pkt(mk(6'h28, 4'h9, 4'h0, 1'b0), 8, 0, 0);
    pkt(mk(6'h0C, 4'h0, 4'h1, 1'b0), 4, 40, 0);
    judge(2);
  endtask

  task automatic complete_run();
    $display("Checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  // Reset spans six link cycles so the link side sees it too
  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    errs_seen = 0;
    err_base = 0;
    num_errors = 0;
    checks_done = 0;
    for (int j = 0; j < 128; j++)
      u_dev.pay[j] = 8'(j * 37 + 5);
    for (int j = 100; j < 104; j++)
      u_dev.pay[j] = 8'h00;
    repeat (6) @(posedge link_clk);
    #1;
    reset = 1'b0;
    repeat (4) @(posedge link_clk);
    err_base = errs_seen;
    t_single();
    t_long();
    t_bytes();
    t_faults();
    complete_run();
  end

  // Whole run takes about twelve microseconds; this allows ample margin
  initial begin
    #300000;
    num_errors++;
    complete_run();
  end
endmodule
